// ==== pkg/quad_serial_consts.vh ====
// constants for the four-channel serial output control block
`ifndef QUAD_SERIAL_CONSTS_VH
`define QUAD_SERIAL_CONSTS_VH
`define SAMPLE_BITS 12
`define IDX_W 4
`define IDX_LAST 4'hb
`define IDX_FIRST 4'h0
`define IDX_HALF 4'h6
`define NUM_CHAN 4
`define CLK_NS 25
`define STOP_NS 300
`define RECOVER_NS 100000
`define CNT_W 12
`define CUR_DEFAULT 2'h0
`define ZERO_WORD 12'h000
`endif

// ==== testbench/lane_receiver.sv ====
// deserializing receiver for the four serial lanes
`timescale 1ns/1ps
module lane_receiver
(
   input logic bclk,
   input logic fclk,
   input logic [3:0] din,
   output logic [47:0] word,
   output int frames
);
   logic [47:0] acc;
   int slot = 12;
   logic fprev = 1'b0;
   initial frames = 0;
   // capture 5 ns into the 25 ns bit after every bit clock edge, as a tuned capture point would
   always @(bclk)
   begin
      #5;
      if (fclk && !fprev)
         slot = 0;
      fprev = fclk;
      if (slot < 12)
      begin
         for (int c = 0; c < 4; c++)
            acc[c * 12 + slot] = din[c];
         slot++;
         if (slot == 12)
         begin
            word = acc;
            frames++;
         end
      end
   end
endmodule // lane_receiver

// ==== testbench/quad_serial_out_sva.sv ====
// port assertions for the quad serial output block
`timescale 1ns/1ps
module quad_serial_out_chk
(
   input wire clk,
   input wire rst_b,
   input wire sample_clock_input,
   input wire power_down_pin,
   input wire cfg_reset_b,
   input wire [3:0] chan_power_down,
   input wire [3:0] serial_data_p,
   input wire [3:0] serial_data_n,
   input wire serial_data_oe_b,
   input wire bit_clock_pair_p,
   input wire frame_clock_pair_p,
   input wire clock_oe_b,
   input wire [1:0] drive_current_r,
   input wire ref_power_down,
   input wire clk_power_down,
   input wire [3:0] chan_off,
   input wire partial_power_down,
   input wire recovering
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);
   logic sc_r;
   logic [4:0] still_r;
   // raw sampling of the sample clock, so the count runs a little ahead of the design's
   always @(posedge clk or negedge rst_b)
      if (!rst_b)
      begin
         sc_r <= 1'b0;
         still_r <= 5'h0;
      end
      else
      begin
         sc_r <= sample_clock_input;
         still_r <= (sc_r != sample_clock_input) ? 5'h0 : still_r + {4'h0, still_r != 5'h1f};
      end
   a_bit_toggle: assert property (
      !clock_oe_b && !$past(clock_oe_b) && !partial_power_down
      |-> bit_clock_pair_p != $past(bit_clock_pair_p)) else $error("bit clock stalled");
   a_data_pair: assert property (
      !serial_data_oe_b |-> serial_data_n == ~serial_data_p) else $error("data pair");
   a_frame_high: assert property (
      $rose(frame_clock_pair_p) |-> (frame_clock_pair_p || clock_oe_b)[*6]
      ##1 (!frame_clock_pair_p || clock_oe_b)) else $error("frame high length");
   a_pd_all: assert property (
      power_down_pin[*5] |-> serial_data_oe_b && clock_oe_b && ref_power_down
      && clk_power_down && chan_off == 4'hf) else $error("power down");
   a_chan_map: assert property (
      (cfg_reset_b && !power_down_pin && $stable(chan_power_down))[*5]
      |-> chan_off == chan_power_down) else $error("channel off map");
   a_stop_detect: assert property (
      still_r >= 5'h12 |-> partial_power_down) else $error("clock stop missed");
   a_cfg_zero: assert property (
      !cfg_reset_b[*5] |-> drive_current_r == 2'h0 && serial_data_p == 4'h0)
      else $error("config reset");
   a_recover_quiet: assert property (
      recovering && $past(recovering) |-> serial_data_p == 4'h0) else $error("recovery data");
   c_stop: cover property ($rose(partial_power_down));
   c_recover: cover property ($fell(recovering));
   c_cfg_frame: cover property (!cfg_reset_b && $rose(frame_clock_pair_p));
endmodule // quad_serial_out_chk
bind quad_serial_out quad_serial_out_chk chk (.clk, .rst_b, .sample_clock_input,
   .power_down_pin, .cfg_reset_b, .chan_power_down, .serial_data_p, .serial_data_n,
   .serial_data_oe_b, .bit_clock_pair_p, .frame_clock_pair_p, .clock_oe_b, .drive_current_r,
   .ref_power_down, .clk_power_down, .chan_off, .partial_power_down, .recovering);

// ==== testbench/quad_serial_out_test.sv ====
// self-checking bench for the quad serial output block
`timescale 1ns/1ps
module quad_serial_out_test;
   localparam int RC = 20;
   localparam logic [47:0] W = 48'h8c15_a3f0_e247;
   logic clk = 0, rst_b = 0, sample_clock_input = 0, power_down_pin = 0, cfg_reset_b = 1;
   logic msb_first = 0, deskew_en = 0, sync_en = 0, custom_en = 0, run = 1;
   logic [47:0] sample_word = W, word, e;
   logic [11:0] custom_pattern = 12'h5a3;
   logic [3:0] chan_power_down = 4'h0, serial_data_p, serial_data_n, chan_off;
   logic [1:0] drive_current_sel = 2'h0, drive_current_r;
   logic serial_data_oe_b, bit_clock_pair_p, bit_clock_pair_n, frame_clock_pair_p;
   logic frame_clock_pair_n, clock_oe_b, ref_power_down, clk_power_down;
   logic partial_power_down, recovering;
   int frames, err_count = 0, checks_done = 0;
   always #12.5 clk = ~clk;
   always #100 if (run) sample_clock_input = ~sample_clock_input;
   quad_serial_out #(.RECOVER_CYC(RC)) uut (.clk, .rst_b, .sample_clock_input, .power_down_pin,
      .cfg_reset_b, .sample_word, .msb_first, .deskew_en, .sync_en, .custom_en, .custom_pattern,
      .chan_power_down, .drive_current_sel, .serial_data_p, .serial_data_n, .serial_data_oe_b,
      .bit_clock_pair_p, .bit_clock_pair_n, .frame_clock_pair_p, .frame_clock_pair_n,
      .clock_oe_b, .drive_current_r, .ref_power_down, .clk_power_down, .chan_off,
      .partial_power_down, .recovering);
   lane_receiver rx (.bclk(bit_clock_pair_p), .fclk(frame_clock_pair_p), .din(serial_data_p),
      .word, .frames);
   task automatic chk(input logic [47:0] seen, input logic [47:0] exp);
      checks_done++;
      if (seen !== exp)
      begin
         err_count++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic close_out();
      $display("checks %0d errors %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask
   // three frames so that at least one is wholly after a change
   task automatic fwait(input int n);
      int f0;
      int k;
      f0 = frames;
      for (k = 0; k < 40 * n && frames < f0 + n; k++)
         @(posedge clk);
      if (frames < f0 + n)
      begin
         err_count++;
         close_out();
      end
   endtask
   task automatic data_order();
      fwait(3);
      chk(word, W);
      msb_first <= 1'b1;
      fwait(3);
      for (int k = 0; k < 48; k++)
         e[k] = W[k - k % 12 + 11 - k % 12];
      chk(word, e);
      msb_first <= 1'b0;
   endtask
   task automatic test_patterns();
      logic [2:0] m [4] = '{3'h4, 3'h2, 3'h1, 3'h7};
      logic [11:0] p [4] = '{12'haaa, 12'hfc0, 12'h5a3, 12'haaa};
      for (int i = 0; i < 4; i++)
      begin
         {deskew_en, sync_en, custom_en} <= m[i];
         fwait(3);
         chk(word, {4{p[i]}});
      end
      {deskew_en, sync_en, custom_en} <= 3'h0;
   endtask
   task automatic power_modes();
      chan_power_down <= 4'h5;
      fwait(3);
      chk(word, W & 48'hfff0_00ff_f000);
      chk(chan_off, 4'h5);
      chan_power_down <= 4'h0;
      power_down_pin <= 1'b1;
      cyc(6);
      chk({serial_data_oe_b, clock_oe_b, ref_power_down, clk_power_down, chan_off}, 8'hff);
      power_down_pin <= 1'b0;
      cyc(6);
      chk({serial_data_oe_b, clock_oe_b}, 2'h0);
      chk({bit_clock_pair_p ^ bit_clock_pair_n, frame_clock_pair_p ^ frame_clock_pair_n}, 2'h3);
      chk(serial_data_p ^ serial_data_n, 4'hf);
   endtask
   task automatic clock_stop();
      run <= 1'b0;
      cyc(24);
      chk(partial_power_down, 1'b1);
      run <= 1'b1;
      cyc(18);
      chk({partial_power_down, recovering}, 2'h1);
      cyc(RC + 10);
      chk(recovering, 1'b0);
      fwait(3);
      chk(word, W);
   endtask
   task automatic cfg_reset();
      drive_current_sel <= 2'h3;
      cyc(3);
      chk(drive_current_r, 2'h3);
      cfg_reset_b <= 1'b0;
      cyc(6);
      chk(drive_current_r, 2'h0);
      fwait(3);
      chk(word, 48'h0);
      cfg_reset_b <= 1'b1;
   endtask
   initial
   begin
      cyc(10);
      rst_b <= 1'b1;
      cyc(4);
      cfg_reset_b <= 1'b0;
      cyc(4);
      cfg_reset_b <= 1'b1;
      cyc(4);
      data_order();
      test_patterns();
      power_modes();
      clock_stop();
      cfg_reset();
      close_out();
   end
endmodule // quad_serial_out_test

// ==== verilog/quad_serial_out.v ====
// serial output and control logic of a four-channel 12-bit converter
// Function
// - each channel's 12-bit sample leaves on its own serial stream
// - one serial bit is shifted per fast clock cycle, twelve per sample
// - least significant bit first by default; a setting gives msb first
// - bit clock at six times sample rate goes out; receiver captures with it
// - frame clock at sample rate marks start of each 12-bit frame
// - deskew mode sends alternating zeros and ones
// - sync mode sends six zeros then six ones every frame
// - a user custom pattern may replace converted data
// - four drive current settings, default setting after reset
// - power-down pin high shuts reference, clock circuitry and channels
// - in power-down all serial drivers are high impedance
// - each channel can be powered down on its own
// - sample clock stopped over 300 ns or below 3 MHz gives partial power-down
// - after clock resumes, about 100 us passes before normal operation
// - reset returns every configuration register to zero
// - while reset is active all channels send zero code
// - bit clock and frame clock keep running during reset
`timescale 1ns/1ps
`include "quad_serial_consts.vh"
module quad_serial_out
#(
   parameter RECOVER_CYC = (`RECOVER_NS + `CLK_NS - 1) / `CLK_NS
)
(
   input wire clk,
   input wire rst_b,
   input wire sample_clock_input,
   input wire power_down_pin,
   input wire cfg_reset_b,
   input wire [47:0] sample_word,
   input wire msb_first,
   input wire deskew_en,
   input wire sync_en,
   input wire custom_en,
   input wire [11:0] custom_pattern,
   input wire [3:0] chan_power_down,
   input wire [1:0] drive_current_sel,
   output reg [3:0] serial_data_p,
   output reg [3:0] serial_data_n,
   output reg serial_data_oe_b,
   output reg bit_clock_pair_p,
   output reg bit_clock_pair_n,
   output reg frame_clock_pair_p,
   output reg frame_clock_pair_n,
   output reg clock_oe_b,
   output reg [1:0] drive_current_r,
   output reg ref_power_down,
   output reg clk_power_down,
   output reg [3:0] chan_off,
   output reg partial_power_down,
   output reg recovering
);
   // twelve cycles with no rising edge covers a stop and a clock below 3 MHz
   localparam [`CNT_W-1:0] STOP_CYC = `STOP_NS / `CLK_NS;
   localparam [`CNT_W-1:0] RECOV_CYC_W = RECOVER_CYC[`CNT_W-1:0];

   // one-hot supervisor states
   localparam [2:0] ST_RUN = 3'b001;
   localparam [2:0] ST_STOPPED = 3'b010;
   localparam [2:0] ST_RECOVER = 3'b100;

   wire rst_sync_b;
   wire samp_clk_s;
   wire pd_s;
   wire cfg_rst_s_b;

   reg samp_clk_d_r;
   reg [`IDX_W-1:0] idx_r;
   reg [`IDX_W-1:0] idx_nxt;
   reg bit_clk_r;
   reg [47:0] held_r;
   reg [47:0] frame_word_r;
   reg msb_first_r;
   reg deskew_r;
   reg sync_r;
   reg custom_r;
   reg [11:0] custom_pat_r;
   reg [3:0] chan_pd_r;
   reg [2:0] state_r;
   reg [2:0] state_nxt;
   reg [`CNT_W-1:0] gap_cnt_r;
   reg [`CNT_W-1:0] rec_cnt_r;
   reg [3:0] bit_nxt;
   reg pattern_bit;
   reg [11:0] word_c;
   integer ch;

   wire samp_edge = samp_clk_s & ~samp_clk_d_r;
   wire frame_end = (idx_r == `IDX_LAST);
   wire stopped_now = (gap_cnt_r >= STOP_CYC);
   wire normal = (state_r == ST_RUN);

   // bit position taken from the word, honouring the chosen order
   function sel_bit;
      input [11:0] word;
      input [`IDX_W-1:0] idx;
      input msb;
      begin
         if (msb)
            sel_bit = word[`IDX_LAST - idx];
         else
            sel_bit = word[idx];
      end
   endfunction

   // frame clock is high for the first half of the frame
   function first_half;
      input [`IDX_W-1:0] idx;
      begin
         first_half = (idx < `IDX_HALF);
      end
   endfunction

   // reset leaves through two flops so no register sees a release near an edge
   sync_two_stage #(.WIDTH(1)) u_rst_sync
   (
      .clk(clk),
      .rst_b(rst_b),
      .d(1'b1),
      .q(rst_sync_b)
   );

   sync_two_stage #(.WIDTH(3)) u_pin_sync
   (
      .clk(clk),
      .rst_b(rst_sync_b),
      .d({sample_clock_input, power_down_pin, cfg_reset_b}),
      .q({samp_clk_s, pd_s, cfg_rst_s_b})
   );

   // configuration registers, cleared by the reset pulse
   always @(posedge clk or negedge rst_sync_b)
   begin
      if (!rst_sync_b)
      begin
         msb_first_r <= 1'b0;
         deskew_r <= 1'b0;
         sync_r <= 1'b0;
         custom_r <= 1'b0;
         custom_pat_r <= `ZERO_WORD;
         chan_pd_r <= 4'h0;
         drive_current_r <= `CUR_DEFAULT;
      end
      else if (!cfg_rst_s_b)
      begin
         msb_first_r <= 1'b0;
         deskew_r <= 1'b0;
         sync_r <= 1'b0;
         custom_r <= 1'b0;
         custom_pat_r <= `ZERO_WORD;
         chan_pd_r <= 4'h0;
         drive_current_r <= `CUR_DEFAULT;
      end
      else
      begin
         msb_first_r <= msb_first;
         deskew_r <= deskew_en;
         sync_r <= sync_en;
         custom_r <= custom_en;
         custom_pat_r <= custom_pattern;
         chan_pd_r <= chan_power_down;
         drive_current_r <= drive_current_sel;
      end
   end

   // sample clock edges and the gap since the last one
   always @(posedge clk or negedge rst_sync_b)
   begin
      if (!rst_sync_b)
      begin
         samp_clk_d_r <= 1'b0;
         gap_cnt_r <= {`CNT_W{1'b0}};
         held_r <= 48'h0000_0000_0000;
      end
      else
      begin
         samp_clk_d_r <= samp_clk_s;
         if (samp_edge)
         begin
            gap_cnt_r <= {`CNT_W{1'b0}};
            // the word waits here until the current frame has ended
            held_r <= sample_word;
         end
         else if (!stopped_now)
            gap_cnt_r <= gap_cnt_r + 1'b1;
      end
   end

   // clock-stop supervisor: stopped, then timed recovery
   always @*
   begin
      state_nxt = state_r;
      case (state_r)
         ST_RUN:
            if (stopped_now)
               state_nxt = ST_STOPPED;
         ST_STOPPED:
            if (samp_edge)
               state_nxt = ST_RECOVER;
         // a stop during recovery restarts the wait from the next edge
         ST_RECOVER:
            if (stopped_now)
               state_nxt = ST_STOPPED;
            else if (rec_cnt_r >= RECOV_CYC_W)
               state_nxt = ST_RUN;
         default:
            state_nxt = ST_RUN;
      endcase
   end

   always @(posedge clk or negedge rst_sync_b)
   begin
      if (!rst_sync_b)
      begin
         state_r <= ST_RUN;
         rec_cnt_r <= {`CNT_W{1'b0}};
         partial_power_down <= 1'b0;
         recovering <= 1'b0;
      end
      else
      begin
         state_r <= state_nxt;
         if (state_nxt == ST_RECOVER)
            rec_cnt_r <= rec_cnt_r + 1'b1;
         else
            rec_cnt_r <= {`CNT_W{1'b0}};
         partial_power_down <= (state_nxt == ST_STOPPED);
         recovering <= (state_nxt == ST_RECOVER);
      end
   end

   // frame position: the fast clock is clk, twelve bits per frame
   always @*
   begin
      if (frame_end)
         idx_nxt = `IDX_FIRST;
      else
         idx_nxt = idx_r + 1'b1;
   end

   // pattern bit for the next slot, shared by all channels
   always @*
   begin
      if (deskew_r)
         pattern_bit = idx_nxt[0];
      else if (sync_r)
         pattern_bit = ~first_half(idx_nxt);
      else
         pattern_bit = sel_bit(custom_pat_r, idx_nxt, msb_first_r);
   end

   always @*
   begin
      bit_nxt = 4'h0;
      word_c = `ZERO_WORD;
      for (ch = 0; ch < `NUM_CHAN; ch = ch + 1)
      begin
         // slot 0 is launched in the cycle the new word loads, so take it from held_r
         if (frame_end)
            word_c = held_r[ch*`SAMPLE_BITS +: `SAMPLE_BITS];
         else
            word_c = frame_word_r[ch*`SAMPLE_BITS +: `SAMPLE_BITS];
         // zero code while in reset, powered down or not yet recovered
         if (!cfg_rst_s_b || chan_pd_r[ch] || !normal || pd_s)
            bit_nxt[ch] = 1'b0;
         else if (deskew_r || sync_r || custom_r)
            bit_nxt[ch] = pattern_bit;
         else
            bit_nxt[ch] = sel_bit(word_c, idx_nxt, msb_first_r);
      end
   end

   // bit and frame clocks run regardless of the reset pulse
   // both halves of each pair are registered so they never skew apart
   always @(posedge clk or negedge rst_sync_b)
   begin
      if (!rst_sync_b)
      begin
         idx_r <= `IDX_LAST;
         bit_clk_r <= 1'b0;
         frame_word_r <= 48'h0000_0000_0000;
         serial_data_p <= 4'h0;
         serial_data_n <= 4'hf;
         bit_clock_pair_p <= 1'b0;
         bit_clock_pair_n <= 1'b1;
         frame_clock_pair_p <= 1'b0;
         frame_clock_pair_n <= 1'b1;
      end
      else
      begin
         idx_r <= idx_nxt;
         // toggling every bit slot gives six clock periods per frame
         bit_clk_r <= ~bit_clk_r;
         bit_clock_pair_p <= ~bit_clk_r;
         bit_clock_pair_n <= bit_clk_r;
         frame_clock_pair_p <= first_half(idx_nxt);
         frame_clock_pair_n <= ~first_half(idx_nxt);
         if (frame_end)
            frame_word_r <= held_r;
         serial_data_p <= bit_nxt;
         serial_data_n <= ~bit_nxt;
      end
   end

   // power-down pin: everything off, drivers released
   // drive current is only a code here; the output stage decodes it
   always @(posedge clk or negedge rst_sync_b)
   begin
      if (!rst_sync_b)
      begin
         serial_data_oe_b <= 1'b1;
         clock_oe_b <= 1'b1;
         ref_power_down <= 1'b0;
         clk_power_down <= 1'b0;
         chan_off <= 4'h0;
      end
      else
      begin
         serial_data_oe_b <= pd_s;
         clock_oe_b <= pd_s;
         ref_power_down <= pd_s;
         clk_power_down <= pd_s;
         chan_off <= chan_pd_r | {4{pd_s}};
      end
   end
endmodule // quad_serial_out

// ==== verilog/sync_two_stage.v ====
// two-flop synchroniser for levels arriving from outside the clk domain
`timescale 1ns/1ps
module sync_two_stage
#(
   parameter WIDTH = 1
)
(
   input wire clk,
   input wire rst_b,
   input wire [WIDTH-1:0] d,
   output wire [WIDTH-1:0] q
);
   reg [WIDTH-1:0] meta_r;
   reg [WIDTH-1:0] stable_r;

   always @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         meta_r <= {WIDTH{1'b0}};
         stable_r <= {WIDTH{1'b0}};
      end
      else
      begin
         meta_r <= d;
         stable_r <= meta_r;
      end
   end

   assign q = stable_r;
endmodule // sync_two_stage
